// ---- hw/vtp_top.sv ----
// vtp_top.sv: test pattern control registers and pixel generator
// assumes: AHB-Lite single master, one 40 MHz clock, pixel sink with ready
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "vtp_defines.svh"

module vtp_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [23:0] pix_rgb,
    output logic pix_frame_start,
    output logic pix_line_start,
    output logic loop_through_driver_pwdn
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    // async assert, two-flop synchronous release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic [7:0] frames;
        logic pwdn;
        logic [10:0] hcnt;
        logic [10:0] vcnt;
        logic [7:0] frame_cnt;
        logic [3:0] scroll_sel;
        logic [1:0] div;
    } vtp_state_t;

    vtp_state_t s_q;
    vtp_state_t s_d;
    logic fifo_ready;
    logic gen_valid;
    logic [23:0] gen_rgb;
    logic pix_tick;
    logic [7:0] hlev;
    logic [7:0] vlev;
    logic [3:0] sel;
    logic [23:0] base;
    logic [23:0] ramp_tgt;
    logic [7:0] lev;
    logic [2:0] bar;
    logic [1:0] band;
    vtp_pkg::vtp_mode_t mode;

    // ----------------------------------------
    // pattern selection
    // ----------------------------------------
    // ramp levels: position scaled to 0..255 over active region
    // even ramp spread
    // product widened first, an 11-bit product would wrap past column 7
    assign hlev = 8'(({8'h00, s_q.hcnt} * 19'd256) / {8'h00, `VTP_H_ACTIVE});
    assign vlev = 8'(({8'h00, s_q.vcnt} * 19'd256) / {8'h00, `VTP_V_ACTIVE});
    assign bar = 3'((s_q.hcnt * 11'd8) / `VTP_H_ACTIVE);
    assign band = 2'((s_q.vcnt * 11'd4) / `VTP_V_ACTIVE);

    assign sel = s_q.cfg[`VTP_BIT_SCROLL] ? s_q.scroll_sel : s_q.ctrl[`VTP_SEL_HI:`VTP_SEL_LO];

    // class of pattern with fixed priority
    always_comb
    begin
        if (!s_q.ctrl[`VTP_BIT_EN])
        begin
            mode = vtp_pkg::VTP_OFF;
        end
        else if (s_q.ctrl[`VTP_BIT_COMPLY])
        begin
            mode = vtp_pkg::VTP_COMPLY;
        end
        else if (s_q.ctrl[`VTP_BIT_BARS])
        begin
            mode = vtp_pkg::VTP_BARS;
        end
        else if (sel >= 4'h1 && sel <= 4'h5)
        begin
            mode = vtp_pkg::VTP_SOLID;
        end
        else if (sel >= 4'h6 && sel <= 4'h9)
        begin
            mode = vtp_pkg::VTP_HRAMP;
        end
        else if (sel >= 4'ha && sel <= 4'hd)
        begin
            mode = vtp_pkg::VTP_VRAMP;
        end
        // custom colour, reserved codes output black
        else if (sel == 4'he)
        begin
            mode = vtp_pkg::VTP_CUSTOM;
        end
        else
        begin
            mode = vtp_pkg::VTP_OFF;
        end
    end

    // ramp target colour: white, red, green, blue by low code
    always_comb
    begin
        case (2'(sel - ((mode == vtp_pkg::VTP_HRAMP) ? 4'h6 : 4'ha)))
            2'd0: ramp_tgt = 24'hffffff;
            2'd1: ramp_tgt = 24'hff0000;
            2'd2: ramp_tgt = 24'h00ff00;
            default: ramp_tgt = 24'h0000ff;
        endcase
    end

    assign lev = (mode == vtp_pkg::VTP_HRAMP) ? hlev : vlev;

    // colour before inversion
    always_comb
    begin
        base = 24'h000000;
        case (mode)
            vtp_pkg::VTP_SOLID:
            begin
                case (sel)
                    4'h1: base = 24'hffffff;
                    4'h2: base = 24'h000000;
                    4'h3: base = 24'hff0000;
                    4'h4: base = 24'h00ff00;
                    default: base = 24'h0000ff;
                endcase
            end
            vtp_pkg::VTP_HRAMP, vtp_pkg::VTP_VRAMP: base = ramp_tgt & {3{lev}};
            vtp_pkg::VTP_CUSTOM: base = {s_q.red, s_q.green, s_q.blue};
            vtp_pkg::VTP_BARS:
            begin
                case (bar)
                    3'd0: base = 24'hffffff;
                    3'd1: base = 24'hffff00;
                    3'd2: base = 24'h00ffff;
                    3'd3: base = 24'h00ff00;
                    3'd4: base = 24'hff00ff;
                    3'd5: base = 24'hff0000;
                    3'd6: base = 24'h0000ff;
                    default: base = 24'h000000;
                endcase
            end
            vtp_pkg::VTP_COMPLY:
            begin
                // four bands top to bottom; band order swaps first and third band
                case ((s_q.ctrl[`VTP_BIT_BANDREV] && !band[0]) ? {~band[1], band[0]} : band)
                    2'd0: base = 24'hffff00;
                    2'd1: base = 24'h00ffff;
                    2'd2: base = 24'h0000ff;
                    default: base = 24'hff0000;
                endcase
            end
            default: base = 24'h000000;
        endcase
    end

    assign gen_rgb = (s_q.cfg[`VTP_BIT_INV] && mode != vtp_pkg::VTP_OFF) ? ~base : base;
    assign pix_tick = (s_q.div == `VTP_PIX_DIV);
    assign gen_valid = pix_tick && (s_q.hcnt < `VTP_H_ACTIVE) && (s_q.vcnt < `VTP_V_ACTIVE);

    // ----------------------------------------
    // next state: bus and raster
    // ----------------------------------------
    always_comb
    begin
        s_d = s_q;
        // write data phase follows the registered address phase
        if (s_q.wr_pend)
        begin
            if (s_q.wr_addr == `VTP_ADDR_CTRL) s_d.ctrl = hwdata[7:0];
            else if (s_q.wr_addr == `VTP_ADDR_CFG) s_d.cfg = {6'h00, hwdata[1:0]};
            else if (s_q.wr_addr == `VTP_ADDR_RED) s_d.red = hwdata[7:0];
            else if (s_q.wr_addr == `VTP_ADDR_GREEN) s_d.green = hwdata[7:0];
            else if (s_q.wr_addr == `VTP_ADDR_BLUE) s_d.blue = hwdata[7:0];
            else if (s_q.wr_addr == `VTP_ADDR_FRAMES) s_d.frames = hwdata[7:0];
            else if (s_q.wr_addr == `VTP_ADDR_PWDN) s_d.pwdn = hwdata[0];
        end
        s_d.wr_pend = hsel && hready && htrans[1] && hwrite;
        s_d.wr_addr = haddr;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            // forward a write landing this cycle so a pipelined read sees it
            if (haddr == `VTP_ADDR_CTRL) s_d.rdata = {24'h0, s_d.ctrl};
            else if (haddr == `VTP_ADDR_CFG) s_d.rdata = {24'h0, s_d.cfg};
            else if (haddr == `VTP_ADDR_RED) s_d.rdata = {24'h0, s_d.red};
            else if (haddr == `VTP_ADDR_GREEN) s_d.rdata = {24'h0, s_d.green};
            else if (haddr == `VTP_ADDR_BLUE) s_d.rdata = {24'h0, s_d.blue};
            else if (haddr == `VTP_ADDR_FRAMES) s_d.rdata = {24'h0, s_d.frames};
            else if (haddr == `VTP_ADDR_STATUS)
                s_d.rdata = {16'h0000, fifo_ready, mode, s_q.scroll_sel, s_q.frame_cnt};
            else if (haddr == `VTP_ADDR_PWDN) s_d.rdata = {31'h0, s_d.pwdn};
            else s_d.rdata = 32'h0;
        end
        // raster advances only when the fifo can take the pixel
        if (!s_q.ctrl[`VTP_BIT_EN])
        begin
            s_d.hcnt = '0;
            s_d.vcnt = '0;
            s_d.div = '0;
            s_d.frame_cnt = '0;
            s_d.scroll_sel = 4'h1;
        end
        else if (!pix_tick)
        begin
            s_d.div = 2'(s_q.div + 2'd1);
        end
        else if (fifo_ready)
        begin
            s_d.div = '0;
            s_d.hcnt = 11'(s_q.hcnt + 11'd1);
            if (s_q.hcnt == `VTP_H_TOTAL - 11'd1)
            begin
                s_d.hcnt = '0;
                s_d.vcnt = 11'(s_q.vcnt + 11'd1);
                if (s_q.vcnt == `VTP_V_TOTAL - 11'd1)
                begin
                    s_d.vcnt = '0;
                    s_d.frame_cnt = 8'(s_q.frame_cnt + 8'd1);
                    if (s_q.cfg[`VTP_BIT_SCROLL] && s_d.frame_cnt >= s_q.frames)
                    begin
                        s_d.frame_cnt = '0;
                        s_d.scroll_sel = (s_q.scroll_sel == 4'he) ? 4'h1 : 4'(s_q.scroll_sel + 4'h1);
                    end
                end
            end
        end
    end

    // state register, control reset values
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.ctrl <= `VTP_CTRL_RESET;
            s_q.frames <= `VTP_FRAMES_RESET;
            s_q.scroll_sel <= 4'h1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign loop_through_driver_pwdn = s_q.pwdn;

    // ----------------------------------------
    // output buffer
    // ----------------------------------------
    // fifo decouples the raster from a stalling display sink
    vtp_fifo #(
        .WIDTH(`VTP_FIFO_WIDTH),
        .DEPTH(`VTP_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(gen_valid),
        .in_ready(fifo_ready),
        .in_data({s_q.hcnt == 11'd0 && s_q.vcnt == 11'd0, s_q.hcnt == 11'd0, gen_rgb}),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data({pix_frame_start, pix_line_start, pix_rgb})
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // disabled generator idles raster
    a_disabled_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.ctrl[0] |=> s_q.hcnt == 11'd0 && !gen_valid) else $error("raster ran while disabled");
    a_comply_prio: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctrl[0] && s_q.ctrl[3] |-> mode == vtp_pkg::VTP_COMPLY) else $error("compliance lost");
    a_bars_prio: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctrl[0] && !s_q.ctrl[3] && s_q.ctrl[2] |-> mode == vtp_pkg::VTP_BARS)
        else $error("bars not chosen");
    a_solid_white: assert property (@(posedge clk) disable iff (!rst_n)
        mode == vtp_pkg::VTP_SOLID && sel == 4'h1 && !s_q.cfg[1] |-> gen_rgb == 24'hffffff)
        else $error("white wrong");
    a_invert_pair: assert property (@(posedge clk) disable iff (!rst_n)
        mode == vtp_pkg::VTP_SOLID && sel == 4'h3 && s_q.cfg[1] |-> gen_rgb == 24'h00ffff)
        else $error("cyan wrong");
    a_hramp_start: assert property (@(posedge clk) disable iff (!rst_n)
        mode == vtp_pkg::VTP_HRAMP && s_q.hcnt == 11'd0 && !s_q.cfg[1] |-> gen_rgb == 24'h0)
        else $error("ramp not black");
    a_scroll_sel: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.cfg[0] |-> sel == s_q.scroll_sel) else $error("field used in scroll");
    a_custom_rgb: assert property (@(posedge clk) disable iff (!rst_n)
        mode == vtp_pkg::VTP_CUSTOM && !s_q.cfg[1] |-> gen_rgb == {s_q.red, s_q.green, s_q.blue})
        else $error("custom wrong");
    c_bars: cover property (@(posedge clk) disable iff (!rst_n) mode == vtp_pkg::VTP_BARS && gen_valid);
    c_scroll: cover property (@(posedge clk) disable iff (!rst_n) $changed(s_q.scroll_sel));
    c_stall: cover property (@(posedge clk) disable iff (!rst_n) !fifo_ready);
endmodule : vtp_top
`default_nettype wire

// ---- hw/vtp_defines.svh ----
// vtp_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from design files, definitions only
`ifndef VTP_DEFINES_SVH
`define VTP_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
// control, config and power-down sit at word indices; byte address is index times four
`define VTP_IDX_PWDN 10'h063
`define VTP_IDX_CTRL 10'h064
`define VTP_IDX_CFG 10'h065
`define VTP_ADDR_CTRL {`VTP_IDX_CTRL, 2'b00}
`define VTP_ADDR_CFG {`VTP_IDX_CFG, 2'b00}
`define VTP_ADDR_RED 12'h070
`define VTP_ADDR_GREEN 12'h074
`define VTP_ADDR_BLUE 12'h078
`define VTP_ADDR_FRAMES 12'h07c
`define VTP_ADDR_STATUS 12'h080
`define VTP_ADDR_PWDN {`VTP_IDX_PWDN, 2'b00}

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define VTP_CTRL_RESET 8'h10
`define VTP_SEL_HI 7
`define VTP_SEL_LO 4
`define VTP_BIT_COMPLY 3
`define VTP_BIT_BARS 2
`define VTP_BIT_BANDREV 1
`define VTP_BIT_EN 0
`define VTP_BIT_INV 1
`define VTP_BIT_SCROLL 0
`define VTP_FRAMES_RESET 8'h01

// ----------------------------------------
// frame geometry and pixel rate
// ----------------------------------------
`define VTP_H_ACTIVE 11'd256
`define VTP_V_ACTIVE 11'd256
`define VTP_H_TOTAL 11'd264
`define VTP_V_TOTAL 11'd260
`define VTP_PIX_DIV 2'd1
`define VTP_FIFO_DEPTH 32
`define VTP_FIFO_WIDTH 26

`endif

// ---- hw/vtp_pkg.sv ----
// vtp_pkg.sv: types shared by the test pattern control files
// assumes: nothing beyond the defines header
package vtp_pkg;
    // pattern class actually driven
    typedef enum logic [2:0]
    {
        VTP_OFF = 3'b000,
        VTP_SOLID = 3'b001,
        VTP_HRAMP = 3'b010,
        VTP_VRAMP = 3'b011,
        VTP_CUSTOM = 3'b100,
        VTP_BARS = 3'b101,
        VTP_COMPLY = 3'b110
    } vtp_mode_t;
endpackage : vtp_pkg

// ---- hw/vtp_fifo.sv ----
// vtp_fifo.sv: synchronous fifo for generated pixels
// assumes: single clock, synchronous active-low reset from the top
`timescale 1ns/100ps
`default_nettype none
module vtp_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // full when pointers differ only in wrap bit
    assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q[AW-1:0]];

    // pointers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule : vtp_fifo
`default_nettype wire

// ---- verification/vtp_sink.sv ----
// vtp_sink.sv: display-side model that takes generated pixels
// assumes: pixel port of vtp_top, one clock, raster order with start marks
`timescale 1ns/100ps
`default_nettype none
module vtp_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic stall,
    input wire logic slow,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [23:0] pix_rgb,
    input wire logic pix_frame_start,
    input wire logic pix_line_start,
    output logic seen,
    output logic [9:0] ax,
    output logic [9:0] ay,
    output logic [23:0] argb
);
    logic phase_q;

    // slow mode takes every other cycle, stall holds off entirely
    assign pix_ready = !stall && (!slow || phase_q);

    // ----------------------------------------
    // coordinates rebuilt from the start marks
    // ----------------------------------------
    // a dropped pixel would shift these and show up as a colour mismatch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= 1'b0;
            seen <= 1'b0;
            ax <= 10'h000;
            ay <= 10'h000;
            argb <= 24'h000000;
        end
        else
        begin
            phase_q <= !phase_q;
            seen <= pix_valid && pix_ready;
            if (pix_valid && pix_ready)
            begin
                argb <= pix_rgb;
                if (pix_frame_start)
                begin
                    ax <= 10'h000;
                    ay <= 10'h000;
                end
                else if (pix_line_start)
                begin
                    ax <= 10'h000;
                    ay <= ay + 10'h001;
                end
                else
                    ax <= ax + 10'h001;
            end
        end
    end
endmodule : vtp_sink
`default_nettype wire

// ---- verification/tb_top.sv ----
// tb_top.sv: self-checking bench for the test pattern control block
// assumes: vtp_top with zero-wait AHB-Lite slave and the vtp_sink model
`timescale 1ns/100ps
`default_nettype none
`include "vtp_defines.svh"
module tb_top;
    typedef struct packed
    {
        logic [7:0] c;
        logic [7:0] g;
        logic [9:0] x;
        logic [9:0] y;
        logic [23:0] e;
    } vtp_tv_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pix_valid, pix_ready, pix_frame_start, pix_line_start;
    logic [23:0] pix_rgb, argb;
    logic pwdn, stall = 1'b0, slow = 1'b0, seen, found;
    logic [9:0] ax, ay;
    logic [31:0] rd;
    int n_fail = 0;
    int check_count = 0;
    vtp_tv_t tv [0:21];
    logic [23:0] bars [0:7];

    // 40 MHz clock; the one slave's hreadyout is the bus hready
    always #12.5 clk = ~clk;
    assign hready = hreadyout;

    vtp_top vtp_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_rgb(pix_rgb), .pix_frame_start(pix_frame_start),
        .pix_line_start(pix_line_start), .loop_through_driver_pwdn(pwdn));
    vtp_sink vtp_sink_inst (.clk(clk), .arst_n(arst_n), .stall(stall), .slow(slow),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_rgb(pix_rgb),
        .pix_frame_start(pix_frame_start), .pix_line_start(pix_line_start),
        .seen(seen), .ax(ax), .ay(ay), .argb(argb));

    // ----------------------------------------
    // bus and pixel tasks
    // ----------------------------------------
    // step past the edge so the design's updates have landed
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : cmp

    // one AHB-Lite single word transfer; waits on hready, no fixed latency
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do tick(); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do tick(); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic do_reset(input int n);
        arst_n <= 1'b0;
        repeat (n) tick();
        arst_n <= 1'b1;
        repeat (3) tick();
    endtask : do_reset

    // fresh reset, then program a pattern and enable the generator
    task automatic start(input logic [7:0] c, input logic [7:0] g);
        do_reset(3);
        bus(1'b1, `VTP_ADDR_PWDN, 8'h01);
        bus(1'b1, `VTP_ADDR_RED, 8'h12);
        bus(1'b1, `VTP_ADDR_GREEN, 8'h34);
        bus(1'b1, `VTP_ADDR_BLUE, 8'h56);
        bus(1'b1, `VTP_ADDR_CFG, g);
        bus(1'b1, `VTP_ADDR_CTRL, c | 8'h01);
    endtask : start

    // wait for the pixel at (x,y) to be taken by the sink and compare it
    // a pixel that never arrives must fail, not compare a stale colour
    task automatic chk(input logic [9:0] x, input logic [9:0] y, input logic [23:0] e);
        int i;
        logic hit;
        hit = 1'b0;
        for (i = 0; i < 60000; i++)
        begin
            tick();
            hit = (seen === 1'b1 && ax === x && ay === y);
            if (hit)
                break;
        end
        cmp({7'h00, hit, argb}, {8'h01, e});
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // hang guard sized well above the expected run length
    initial
    begin
        repeat (95000) @(posedge clk);
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        n_fail++;
        results();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        tv = '{'{8'h10, 8'h00, 10'd7, 10'd0, 24'hffffff}, '{8'h20, 8'h00, 10'd7, 10'd0, 24'h000000},
            '{8'h30, 8'h00, 10'd7, 10'd0, 24'hff0000}, '{8'h40, 8'h00, 10'd7, 10'd0, 24'h00ff00},
            '{8'h50, 8'h00, 10'd7, 10'd0, 24'h0000ff}, '{8'h20, 8'h02, 10'd7, 10'd0, 24'hffffff},
            '{8'h30, 8'h02, 10'd7, 10'd0, 24'h00ffff}, '{8'h50, 8'h02, 10'd7, 10'd0, 24'hffff00},
            '{8'h60, 8'h00, 10'd0, 10'd0, 24'h000000}, '{8'h60, 8'h00, 10'd255, 10'd0, 24'hffffff},
            '{8'h70, 8'h00, 10'd100, 10'd0, 24'h640000}, '{8'h80, 8'h00, 10'd100, 10'd0, 24'h006400},
            '{8'h90, 8'h00, 10'd100, 10'd0, 24'h000064}, '{8'h60, 8'h02, 10'd100, 10'd0, 24'h9b9b9b},
            '{8'ha0, 8'h00, 10'd5, 10'd3, 24'h030303}, '{8'hb0, 8'h00, 10'd5, 10'd3, 24'h030000},
            '{8'hc0, 8'h00, 10'd5, 10'd3, 24'h000300}, '{8'hd0, 8'h02, 10'd5, 10'd3, 24'hfffffc},
            '{8'he0, 8'h00, 10'd9, 10'd0, 24'h123456}, '{8'he0, 8'h02, 10'd9, 10'd0, 24'hedcba9},
            '{8'h38, 8'h00, 10'd0, 10'd0, 24'hffff00}, '{8'h14, 8'h00, 10'd40, 10'd0, 24'hffff00}};
        bars = '{24'hffffff, 24'hffff00, 24'h00ffff, 24'h00ff00,
            24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000};
        do_reset(20);
        bus(1'b0, `VTP_ADDR_CTRL, 8'h00);
        cmp(rd, 32'h00000010);
        bus(1'b0, `VTP_ADDR_CFG, 8'h00);
        cmp(rd, 32'h00000000);
        bus(1'b0, `VTP_ADDR_FRAMES, 8'h00);
        cmp(rd, 32'h00000001);
        bus(1'b1, 12'h0f0, 8'hff);
        bus(1'b0, 12'h0f0, 8'h00);
        cmp(rd, 32'h00000000);
        bus(1'b1, `VTP_ADDR_CFG, 8'h03);
        bus(1'b0, `VTP_ADDR_CFG, 8'h00);
        cmp(rd, 32'h00000003);
        repeat (100) tick();
        cmp({31'h0, pix_valid}, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        $display("test registers done");
        // one fresh start per table line keeps stale pixels out
        for (int k = 0; k < 22; k++)
        begin
            start(tv[k].c, tv[k].g);
            chk(tv[k].x, tv[k].y, tv[k].e);
        end
        cmp({31'h0, pwdn}, 32'h1);
        $display("test pattern table done");
        slow <= 1'b1;
        start(8'h04, 8'h00);
        for (int k = 0; k < 8; k++)
            chk(10'd16 + 10'(32 * k), 10'd0, bars[k]);
        slow <= 1'b0;
        $display("test colour bars done");
        // long stall fills the fifo; nothing may be lost or change
        stall <= 1'b1;
        start(8'h60, 8'h00);
        repeat (200) tick();
        cmp({pix_valid, pix_frame_start, pix_rgb}, {2'b11, 24'h000000});
        stall <= 1'b0;
        chk(10'd100, 10'd0, 24'h646464);
        found = 1'b0;
        for (int i = 0; i < 300 && !found; i++)
        begin
            tick();
            found = (pix_valid === 1'b0);
        end
        cmp({31'h0, found}, 32'h1);
        $display("test stall and drain done");
        start(8'h0a, 8'h00);
        chk(10'd0, 10'd0, 24'h0000ff);
        chk(10'd0, 10'd64, 24'h00ffff);
        $display("test band order done");
        results();
    end
endmodule : tb_top
`default_nettype wire
